// ===== verilog/mdsp_dev.sv
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module mdsp_dev #(
    parameter int unsigned WDOG_CYC_PER_MS_P = mdsp_pkg::WDOG_CYC_PER_MS
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Serial link
    mdsp_if.dev              link,
    // Modem core events and levels
    input  wire logic [15:0] ev_set_i,
    input  wire logic        cd_i,
    input  wire logic        cts_i,
    // FIFO ports
    output logic             tx_push_o,
    output logic      [15:0] tx_data_o,
    output logic             rx_pop_o,
    input  wire logic [15:0] rx_data_i,
    output logic             fifo_flush_o,
    // Configuration to the core
    output logic      [15:0] link_control_o,
    output logic      [15:0] fifo_threshold_o,
    output logic      [15:0] talk_limit_o,
    output logic             reference_enable_o
);
    import mdsp_pkg::*;

    typedef struct packed {
        logic        sclk_s1, sclk_s2, sclk_d;
        logic        cs_s1, cs_s2, cs_d;
        logic        mosi_s1, mosi_s2;
        logic [31:0] rx_sr;
        logic [5:0]  bitcnt;
        logic [31:0] tx_sr;
        logic        skip_first;
        logic [31:0] resp;
        logic [15:0] cfg, status, mask, link_ctl, fifo_thr, talk_lim;
        logic [15:0] tx_data;
        logic        tx_push, rx_pop, flush;
        logic [1:0]  live_d;
        logic        irq_lat;
        logic [2:0]  pcnt;
        logic        irq, oe;
        logic [31:0] wd_cnt;
    } mdsp_dev_s;

    mdsp_dev_s s_reg, s_next;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic        fall, rise, sel, cs_fall, cs_rise, crc_on;
        logic        is_rd, crc_ok, stat_rd, do_srst, wd_kick, active;
        logic [5:0]  need;
        logic [23:0] cmd, rd24;
        logic [6:0]  addr;
        logic [15:0] data, set, w1c;
        logic [31:0] wd_lim;
        fall = s_reg.sclk_d & ~s_reg.sclk_s2;
        rise = ~s_reg.sclk_d & s_reg.sclk_s2;
        sel = ~s_reg.cs_s2;
        cs_fall = s_reg.cs_d & ~s_reg.cs_s2;
        cs_rise = ~s_reg.cs_d & s_reg.cs_s2;
        crc_on = s_reg.cfg[CFG_CRC_EN_BIT];
        need = crc_on ? FRAME_BITS_CRC : FRAME_BITS_PLAIN;
        cmd = crc_on ? s_reg.rx_sr[31:8] : s_reg.rx_sr[23:0];
        is_rd = cmd[CMD_DIR_BIT];
        addr = cmd[22:CMD_ADDR_LSB];
        crc_ok = !crc_on || (crc8(cmd) == s_reg.rx_sr[7:0]);
        rd24 = '0;
        data = '0;
        set = ev_set_i & ~EVENT_LIVE_MASK;
        set[1:0] = {cd_i, cts_i} & ~s_reg.live_d;
        w1c = '0;
        stat_rd = 1'b0;
        do_srst = 1'b0;
        wd_kick = 1'b0;
        s_next = s_reg;
        s_next.tx_push = 1'b0;
        s_next.rx_pop = 1'b0;
        s_next.flush = 1'b0;
        s_next.live_d = {cd_i, cts_i};
        s_next.sclk_s1 = link.sclk;
        s_next.sclk_s2 = s_reg.sclk_s1;
        s_next.sclk_d = s_reg.sclk_s2;
        s_next.cs_s1 = link.cs_n;
        s_next.cs_s2 = s_reg.cs_s1;
        s_next.cs_d = s_reg.cs_s2;
        s_next.mosi_s1 = link.mosi;
        s_next.mosi_s2 = s_reg.mosi_s1;
        // Both supported modes sample on the falling edge
        if (sel && fall) begin
            s_next.rx_sr = {s_reg.rx_sr[30:0], s_reg.mosi_s2};
            if (s_reg.bitcnt != 6'h3F) begin
                s_next.bitcnt = s_reg.bitcnt + 6'h01;
            end
        end
        // Idle-low clock: first rise only launches the preloaded bit
        if (sel && rise) begin
            if (s_reg.skip_first) begin
                s_next.skip_first = 1'b0;
            end else begin
                s_next.tx_sr = {s_reg.tx_sr[30:0],
                                s_reg.cfg[CFG_ECHO_BIT] & s_reg.mosi_s2};
            end
        end
        if (cs_fall) begin
            s_next.tx_sr = crc_on ? s_reg.resp : {s_reg.resp[23:0], 8'h00};
            s_next.skip_first = ~s_reg.sclk_s2;
            s_next.bitcnt = '0;
        end
        // Short frames are dropped whole and leave the response alone
        if (cs_rise && s_reg.bitcnt >= need) begin
            if (!crc_ok) begin
                set[EV_CRC_BIT] = 1'b1;
                // Nothing stored, no pop
                s_next.resp = is_rd ? CRC_BAD_READ : s_reg.rx_sr;
            end else begin
                wd_kick = 1'b1;
                if (is_rd) begin
                    case (addr)
                        OFF_PORT_CONFIG:    data = s_reg.cfg;
                        OFF_EVENT_STATUS: begin
                            data = {s_reg.status[15:2], cd_i, cts_i};
                            stat_rd = 1'b1;
                        end
                        OFF_EVENT_MASK:     data = s_reg.mask;
                        OFF_LINK_CONTROL:   data = s_reg.link_ctl;
                        OFF_RX_FIFO_PORT: begin
                            data = rx_data_i;
                            s_next.rx_pop = 1'b1;
                        end
                        OFF_FIFO_THRESHOLD: data = s_reg.fifo_thr;
                        OFF_TALK_LIMIT:     data = s_reg.talk_lim;
                        default:            data = '0;
                    endcase
                    rd24 = {cmd[23:16], data};
                    s_next.resp = crc_on ? {rd24, crc8(rd24)}
                                         : {8'h00, rd24};
                end else begin
                    // Echo keeps the host's CRC byte
                    s_next.resp = crc_on ? s_reg.rx_sr
                                         : {8'h00, s_reg.rx_sr[23:0]};
                    case (addr)
                        OFF_PORT_CONFIG:
                            s_next.cfg = cmd[15:0] & PORT_CONFIG_WMASK;
                        OFF_SOFT_RESET:
                            do_srst = cmd[SOFT_RESET_BIT];
                        OFF_EVENT_STATUS:   w1c = cmd[15:0];
                        OFF_EVENT_MASK:
                            s_next.mask = cmd[15:0] & EVENT_MASK_WMASK;
                        OFF_LINK_CONTROL:   s_next.link_ctl = cmd[15:0];
                        OFF_TX_FIFO_PORT: begin
                            s_next.tx_data = cmd[15:0];
                            s_next.tx_push = 1'b1;
                        end
                        OFF_FIFO_THRESHOLD: s_next.fifo_thr = cmd[15:0];
                        OFF_TALK_LIMIT:     s_next.talk_lim = cmd[15:0];
                        default: ;
                    endcase
                end
            end
        end
        // Watchdog
        wd_lim = 32'(wdog_ms(s_reg.cfg[15:CFG_WDOG_SEL_LSB])
                     * WDOG_CYC_PER_MS_P);
        if (!s_reg.cfg[CFG_WDOG_EN_BIT] || wd_kick) begin
            s_next.wd_cnt = '0;
        end else if (s_reg.wd_cnt >= wd_lim - 32'h1) begin
            set[EV_WDOG_BIT] = 1'b1;
            s_next.wd_cnt = '0;
        end else begin
            s_next.wd_cnt = s_reg.wd_cnt + 32'h1;
        end
        // Soft reset restores defaults and flushes the core FIFOs
        if (do_srst) begin
            s_next.cfg = PORT_CONFIG_RST;
            s_next.mask = EVENT_MASK_RST;
            s_next.link_ctl = '0;
            s_next.fifo_thr = '0;
            s_next.talk_lim = '0;
            s_next.flush = 1'b1;
            s_next.irq_lat = 1'b0;
            s_next.pcnt = '0;
            set[EV_RST_BIT] = 1'b1;
        end
        // Sticky status: a set in the clearing cycle wins
        s_next.status = (s_reg.status & ~w1c) | set;
        s_next.status[1:0] = 2'b00;
        // Interrupt pin
        if (|(set & ~s_next.mask)) begin
            s_next.irq_lat = 1'b1;
            s_next.pcnt = 3'(IRQ_PULSE_CYC);
        end else begin
            if (stat_rd) begin
                s_next.irq_lat = 1'b0;
            end
            if (s_reg.pcnt != '0) begin
                s_next.pcnt = s_reg.pcnt - 3'h1;
            end
        end
        active = s_reg.cfg[CFG_IRQ_LEVEL_BIT] ? s_next.irq_lat
                                              : (s_next.pcnt != '0);
        s_next.irq = s_reg.cfg[CFG_IRQ_POLARITY_SEL_BIT] ? active : ~active;
        s_next.oe = s_reg.cfg[CFG_TRIST_BIT] ? sel : 1'b1;
        if (rst_i) begin
            s_next = '0;
            s_next.sclk_s1 = 1'b1;
            s_next.sclk_s2 = 1'b1;
            s_next.sclk_d = 1'b1;
            s_next.cs_s1 = 1'b1;
            s_next.cs_s2 = 1'b1;
            s_next.cs_d = 1'b1;
            s_next.cfg = PORT_CONFIG_RST;
            s_next.mask = EVENT_MASK_RST;
            s_next.irq = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        s_reg <= s_next;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign link.miso          = s_reg.tx_sr[31];
    assign link.miso_oe       = s_reg.oe;
    assign link.irq           = s_reg.irq;
    assign tx_push_o          = s_reg.tx_push;
    assign tx_data_o          = s_reg.tx_data;
    assign rx_pop_o           = s_reg.rx_pop;
    assign fifo_flush_o       = s_reg.flush;
    assign link_control_o     = s_reg.link_ctl;
    assign fifo_threshold_o   = s_reg.fifo_thr;
    assign talk_limit_o       = s_reg.talk_lim;
    assign reference_enable_o = s_reg.cfg[CFG_REF_BIT];

endmodule // mdsp_dev
`default_nettype wire

// ===== verilog/mdsp_pkg.sv
package mdsp_pkg;

    // ------------------------------------------------------------
    // Device register offsets (7-bit address field)
    // ------------------------------------------------------------
    localparam logic [6:0] OFF_PORT_CONFIG    = 7'h02;
    localparam logic [6:0] OFF_SOFT_RESET     = 7'h07;
    localparam logic [6:0] OFF_EVENT_STATUS   = 7'h20;
    localparam logic [6:0] OFF_EVENT_MASK     = 7'h21;
    localparam logic [6:0] OFF_LINK_CONTROL   = 7'h22;
    localparam logic [6:0] OFF_TX_FIFO_PORT   = 7'h23;
    localparam logic [6:0] OFF_RX_FIFO_PORT   = 7'h24;
    localparam logic [6:0] OFF_FIFO_THRESHOLD = 7'h25;
    localparam logic [6:0] OFF_TALK_LIMIT     = 7'h27;

    // ------------------------------------------------------------
    // Reset values, writable masks and field positions
    // ------------------------------------------------------------
    localparam logic [15:0] PORT_CONFIG_RST   = 16'h8042;
    localparam logic [15:0] PORT_CONFIG_WMASK = 16'hF05F;
    localparam logic [15:0] EVENT_MASK_RST    = 16'h0024;
    localparam logic [15:0] EVENT_MASK_WMASK  = 16'h7FFF;
    localparam logic [15:0] EVENT_LIVE_MASK   = 16'h0003;
    localparam int CFG_ECHO_BIT      = 0;
    localparam int CFG_TRIST_BIT     = 1;
    localparam int CFG_IRQ_LEVEL_BIT = 2;
    localparam int CFG_IRQ_POLARITY_SEL_BIT   = 3;
    localparam int CFG_CRC_EN_BIT    = 4;
    localparam int CFG_REF_BIT       = 6;
    localparam int CFG_WDOG_EN_BIT   = 12;
    localparam int CFG_WDOG_SEL_LSB  = 13;
    localparam int EV_CRC_BIT        = 8;
    localparam int EV_WDOG_BIT       = 9;
    localparam int EV_RST_BIT        = 15;
    localparam int SOFT_RESET_BIT    = 0;
    localparam int CMD_DIR_BIT       = 23;
    localparam int CMD_ADDR_LSB      = 16;

    // ------------------------------------------------------------
    // Frame format
    // ------------------------------------------------------------
    localparam logic [5:0]  FRAME_BITS_PLAIN = 6'h18;
    localparam logic [5:0]  FRAME_BITS_CRC   = 6'h20;
    localparam logic [7:0]  CRC_POLY         = 8'h07;
    localparam logic [31:0] CRC_BAD_READ     = 32'h80000000;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS    = 10;
    localparam int CLK_HZ           = 100_000_000;
    localparam int WDOG_CYC_PER_MS  = CLK_HZ / 1000;
    localparam int FRAME_GAP_FSK_NS = 2442;
    localparam int FRAME_GAP_MAN_NS = 3000;
    // Strictly more than the longer period, so one spacing fits both modes
    localparam int FRAME_GAP_CYC =
        (FRAME_GAP_MAN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
    localparam int IRQ_PULSE_CYC    = 4;
    localparam int SCLK_HALF_CYC    = 8;

    // ------------------------------------------------------------
    // Host command port
    // ------------------------------------------------------------
    localparam logic [1:0] HOFF_CMD    = 2'h0;
    localparam logic [1:0] HOFF_CFG    = 2'h1;
    localparam logic [1:0] HOFF_STATUS = 2'h2;
    localparam logic [1:0] HOFF_RESP   = 2'h3;
    localparam int HCFG_CRC_BIT  = 0;
    localparam int HCFG_CPOL_BIT = 1;

    function automatic logic [31:0] wdog_ms(input logic [2:0] sel);
        unique case (sel)
            3'h0: return 32'd50;
            3'h1: return 32'd100;
            3'h2: return 32'd500;
            3'h3: return 32'd1000;
            3'h4: return 32'd2000;
            3'h5: return 32'd3000;
            3'h6: return 32'd4000;
            3'h7: return 32'd5000;
        endcase
    endfunction

    // MSB first, zero initial value
    function automatic logic [7:0] crc8(input logic [23:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 23; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
        end
        return c;
    endfunction

endpackage

// ===== verilog/mdsp_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mdsp_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic miso_line;
    logic irq;

    // Undriven serial output reads as a pulled-up line
    assign miso_line = miso_oe ? miso : 1'b1;

    modport dev  (input sclk, cs_n, mosi, output miso, miso_oe, irq);
    modport host (output sclk, cs_n, mosi, input miso_line, irq);
endinterface
`default_nettype wire

// ===== verilog/mdsp_host.sv
`timescale 1ns/1ps
`default_nettype none
module mdsp_host (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Serial link
    mdsp_if.host             link,
    // Command port
    input  wire logic [1:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o
);
    import mdsp_pkg::*;

    typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_HOLD, H_GAP} mdsp_host_e;

    typedef struct packed {
        mdsp_host_e  state;
        logic        crc_en, cpol;
        logic [31:0] tx_sr, rx_sr, resp;
        logic        crc_ok;
        logic [8:0]  cnt;
        logic [6:0]  edges;
        logic        sclk, cs_n, mosi;
        logic        miso_s1, miso_s2, irq_s1, irq_s2;
        logic [31:0] rdata;
    } mdsp_host_s;

    mdsp_host_s s_reg, s_next;

    always_comb begin
        logic [6:0]  last;
        logic [23:0] cmd;
        last = s_reg.crc_en ? 7'(2 * FRAME_BITS_CRC)
                            : 7'(2 * FRAME_BITS_PLAIN);
        cmd = wdata_i[23:0];
        s_next = s_reg;
        s_next.miso_s1 = link.miso_line;
        s_next.miso_s2 = s_reg.miso_s1;
        s_next.irq_s1 = link.irq;
        s_next.irq_s2 = s_reg.irq_s1;
        if (rd_i) begin
            unique case (addr_i)
                HOFF_CMD:    s_next.rdata = s_reg.tx_sr;
                HOFF_CFG:    s_next.rdata = {30'h0, s_reg.cpol, s_reg.crc_en};
                HOFF_STATUS: s_next.rdata = {29'h0, s_reg.irq_s2, s_reg.crc_ok,
                                             s_reg.state != H_IDLE};
                HOFF_RESP:   s_next.rdata = s_reg.resp;
            endcase
        end
        if (wr_i && addr_i == HOFF_CFG && s_reg.state == H_IDLE) begin
            s_next.crc_en = wdata_i[HCFG_CRC_BIT];
            s_next.cpol = wdata_i[HCFG_CPOL_BIT];
            s_next.sclk = wdata_i[HCFG_CPOL_BIT];
        end
        unique case (s_reg.state)
            H_IDLE: begin
                if (wr_i && addr_i == HOFF_CMD) begin
                    s_next.tx_sr = s_reg.crc_en ? {cmd, crc8(cmd)}
                                                : {cmd, 8'h00};
                    s_next.cs_n = 1'b0;
                    s_next.edges = '0;
                    s_next.cnt = 9'(SCLK_HALF_CYC - 1);
                    s_next.state = H_SHIFT;
                end
            end
            H_SHIFT: begin
                if (s_reg.cnt != '0) begin
                    s_next.cnt = s_reg.cnt - 9'h1;
                end else begin
                    s_next.cnt = 9'(SCLK_HALF_CYC - 1);
                    s_next.sclk = ~s_reg.sclk;
                    s_next.edges = s_reg.edges + 7'h1;
                    // Sample on falls, launch on rises, in either mode
                    if (s_reg.sclk) begin
                        s_next.rx_sr = {s_reg.rx_sr[30:0], s_reg.miso_s2};
                    end else if (s_reg.edges != '0 || s_reg.cpol) begin
                        s_next.tx_sr = {s_reg.tx_sr[30:0], 1'b0};
                    end
                    if (s_reg.edges + 7'h1 == last) begin
                        s_next.state = H_HOLD;
                    end
                end
            end
            H_HOLD: begin
                if (s_reg.cnt != '0) begin
                    s_next.cnt = s_reg.cnt - 9'h1;
                end else begin
                    s_next.cs_n = 1'b1;
                    s_next.resp = s_reg.crc_en ? s_reg.rx_sr
                                               : {8'h00, s_reg.rx_sr[23:0]};
                    s_next.crc_ok = !s_reg.crc_en ||
                        crc8(s_reg.rx_sr[31:8]) == s_reg.rx_sr[7:0];
                    s_next.cnt = 9'(FRAME_GAP_CYC);
                    s_next.state = H_GAP;
                end
            end
            H_GAP: begin
                if (s_reg.cnt != '0) begin
                    s_next.cnt = s_reg.cnt - 9'h1;
                end else begin
                    s_next.state = H_IDLE;
                end
            end
        endcase
        s_next.mosi = s_next.tx_sr[31];
        if (rst_i) begin
            s_next = '0;
            s_next.state = H_IDLE;
            s_next.cs_n = 1'b1;
            s_next.crc_ok = 1'b1;
            s_next.miso_s1 = 1'b1;
            s_next.miso_s2 = 1'b1;
            s_next.irq_s1 = 1'b1;
            s_next.irq_s2 = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        s_reg <= s_next;
    end

    assign link.sclk = s_reg.sclk;
    assign link.cs_n = s_reg.cs_n;
    assign link.mosi = s_reg.mosi;
    assign rdata_o   = s_reg.rdata;

endmodule // mdsp_host
`default_nettype wire

// ===== verif/mdsp_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module mdsp_asserts (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Link wires
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe,
    input wire logic irq
);
    logic [8:0]  gap_reg;
    logic [5:0]  nb_reg, nbp_reg;
    logic [31:0] mo_reg, mi_reg, mop_reg;
    logic [6:0]  sh_reg, ch_reg;
    logic        seen_reg, rise, csup, ec, eok;
    logic [23:0] pw;
    // ----------
    // Link history
    // ----------
    // Wide windows absorb the device's input synchronisers
    assign csup = cs_n && !ch_reg[0];
    assign rise = |(sh_reg[5:0] & ~sh_reg[6:1]) | (sclk & ~sh_reg[0]);
    assign pw   = (nbp_reg == 6'd32) ? mop_reg[31:8] : mop_reg[23:0];
    assign ec   = csup && seen_reg && nb_reg == nbp_reg && !pw[23];
    assign eok  = (nb_reg == 6'd32) ? mi_reg == mop_reg
                                    : mi_reg[23:0] == mop_reg[23:0];
    always_ff @(posedge clk_i) begin
        sh_reg <= {sh_reg[5:0], sclk};
        ch_reg <= {ch_reg[5:0], cs_n};
        if (rst_i) begin
            gap_reg  <= 9'h0;
            seen_reg <= 1'b0;
            nb_reg   <= 6'h0;
        end else begin
            gap_reg <= cs_n ? gap_reg + {8'h0, gap_reg != 9'h1FF} : 9'h0;
            if (!cs_n && ch_reg[0]) begin
                nb_reg <= 6'h0;
            end else if (!cs_n && sh_reg[0] && !sclk) begin
                nb_reg <= nb_reg + 6'h1;
                mo_reg <= {mo_reg[30:0], mosi};
                mi_reg <= {mi_reg[30:0], miso};
            end
            if (csup) begin
                seen_reg <= 1'b1;
                nbp_reg  <= nb_reg;
                mop_reg  <= mo_reg;
            end
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_reset_quiet: assert property (
        $fell(rst_i) |-> !miso_oe && irq) else $error("outputs busy at reset");
    a_oe_framed: assert property (
        miso_oe |-> ch_reg != 7'h7F) else $error("output driven when idle");
    a_out_edge: assert property (
        !cs_n && ch_reg == 7'h0 && $changed(miso) |-> rise)
        else $error("output moved without clock rise");
    // Past the frame gap the host may switch its idle level between modes
    a_idle_clk: assert property (
        cs_n && ch_reg[0] && gap_reg < 9'd300 |-> $stable(sclk))
        else $error("clock moved idle");
    a_half_period: assert property (
        !cs_n && $changed(sclk) |=> $stable(sclk) [*5])
        else $error("clock half period short");
    a_frame_gap: assert property (
        $fell(cs_n) && seen_reg |-> gap_reg > 9'd300)
        else $error("frames too close");
    a_frame_len: assert property (
        csup |-> nb_reg == 6'd24 || nb_reg == 6'd32)
        else $error("frame bit count wrong");
    a_write_echo: assert property (
        ec |-> eok) else $error("write not echoed");
    c_crc_frame: cover property (csup && nb_reg == 6'd32);
    c_echo: cover property (ec);
    c_irq: cover property ($fell(irq));
    c_idle_high: cover property ($fell(cs_n) && sclk);
endmodule // mdsp_asserts
`default_nettype wire

// ===== verif/modem_spi_host_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module modem_spi_host_port_tb_top;
    import mdsp_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [1:0]  addr_i = 2'h0;
    logic [31:0] wdata_i = 32'h0;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic [15:0] ev_set_i = 16'h0;
    logic [15:0] rx_data_i = 16'h0;
    logic [31:0] rdata_o, r, d;
    logic [15:0] lc_o;
    int          err_count = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    int          n, k;
    logic [6:0]  offs [4] = '{OFF_LINK_CONTROL, OFF_FIFO_THRESHOLD,
                              OFF_TALK_LIMIT, OFF_TX_FIFO_PORT};
    logic [15:0] msk [4] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0000};

    mdsp_if mdsp_if_inst ();
    mdsp_dev #(.WDOG_CYC_PER_MS_P(10)) mdsp_dev_inst (.clk_i(clk_i),
        .rst_i(rst_i), .link(mdsp_if_inst.dev), .ev_set_i(ev_set_i),
        .cd_i(1'b0), .cts_i(1'b0), .tx_push_o(), .tx_data_o(),
        .rx_pop_o(), .rx_data_i(rx_data_i), .fifo_flush_o(),
        .link_control_o(lc_o), .fifo_threshold_o(), .talk_limit_o(),
        .reference_enable_o());
    mdsp_host mdsp_host_inst (.clk_i(clk_i), .rst_i(rst_i),
        .link(mdsp_if_inst.host), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
    mdsp_asserts mdsp_asserts_inst (.clk_i(clk_i), .rst_i(rst_i),
        .sclk(mdsp_if_inst.sclk), .cs_n(mdsp_if_inst.cs_n),
        .mosi(mdsp_if_inst.mosi), .miso(mdsp_if_inst.miso),
        .miso_oe(mdsp_if_inst.miso_oe), .irq(mdsp_if_inst.irq));

    initial begin
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_count++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] crc(input logic [23:0] w);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 23; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction
    task automatic bus(input logic [1:0] a, input logic [31:0] v,
                       input logic w);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= v;
        wr_i    <= w;
        rd_i    <= !w;
        @(posedge clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        #1 r = rdata_o;
    endtask
    // One frame; r ends holding the answer to the frame before it
    task automatic xfer(input logic [23:0] c);
        bus(HOFF_CMD, {8'h0, c}, 1'b1);
        k = 0;
        do begin
            bus(HOFF_STATUS, 32'h0, 1'b0);
            k++;
        end while (r[0] !== 1'b0 && k < 2000);
        chk({31'h0, r[0]}, 32'h0);
        bus(HOFF_RESP, 32'h0, 1'b0);
    endtask
    task automatic ev_pulse(output int lo);
        @(posedge clk_i);
        ev_set_i <= 16'h0010;
        @(posedge clk_i);
        ev_set_i <= 16'h0000;
        lo = 0;
        // The pin answers at the edge that drops the event: count from there
        repeat (10) begin
            #1 lo += int'(mdsp_if_inst.irq === 1'b0);
            @(posedge clk_i);
        end
    endtask
    // ----------
    // Tests
    // ----------
    initial begin
        n = $urandom(29047);
        repeat (8) @(posedge clk_i);
        rst_i     <= 1'b0;
        rx_data_i <= 16'($urandom);
        xfer({1'b1, OFF_PORT_CONFIG, 16'h0});
        xfer({1'b1, OFF_EVENT_MASK, 16'h0});
        chk(r, {9'h1, OFF_PORT_CONFIG, PORT_CONFIG_RST});
        $display("test reset values done");
        foreach (offs[i]) begin
            d = $urandom;
            xfer({1'b0, offs[i], d[15:0]});
            xfer({1'b1, offs[i], 16'h0});
            chk(r, {9'h0, offs[i], d[15:0]});
            xfer({1'b1, OFF_EVENT_STATUS, 16'h0});
            chk(r, {9'h1, offs[i], d[15:0] & msk[i]});
            if (i == 0) chk({16'h0, lc_o}, {16'h0, d[15:0]});
        end
        xfer({1'b1, OFF_RX_FIFO_PORT, 16'h0});
        xfer({1'b1, OFF_EVENT_STATUS, 16'h0});
        chk(r, {9'h1, OFF_RX_FIFO_PORT, rx_data_i});
        $display("test registers done");
        ev_pulse(n);
        chk(32'(n), 32'd4);
        xfer({1'b0, OFF_EVENT_MASK, EVENT_MASK_RST | 16'h0010});
        ev_pulse(n);
        chk(32'(n), 32'd0);
        xfer({1'b0, OFF_EVENT_MASK, EVENT_MASK_RST});
        xfer({1'b0, OFF_PORT_CONFIG, 16'h804E});
        xfer({1'b1, OFF_EVENT_STATUS, 16'h0});
        chk({31'h0, mdsp_if_inst.irq}, 32'h0);
        ev_pulse(n);
        chk({31'h0, mdsp_if_inst.irq}, 32'h1);
        xfer({1'b1, OFF_EVENT_STATUS, 16'h0});
        chk({31'h0, mdsp_if_inst.irq}, 32'h0);
        $display("test interrupt done");
        xfer({1'b0, OFF_PORT_CONFIG, 16'h1042});
        chk({31'h0, r[EV_WDOG_BIT]}, 32'h0);
        repeat (600) @(posedge clk_i);
        xfer({1'b1, OFF_EVENT_STATUS, 16'h0});
        xfer({1'b1, OFF_EVENT_STATUS, 16'h0});
        chk({31'h0, r[EV_WDOG_BIT]}, 32'h1);
        $display("test watchdog done");
        xfer({1'b0, OFF_PORT_CONFIG, 16'h8052});
        // CRC frames run with the idle-high clock, plain ones idle-low
        bus(HOFF_CFG, 32'h3, 1'b1);
        xfer({1'b1, OFF_PORT_CONFIG, 16'h0});
        xfer({1'b0, OFF_TALK_LIMIT, 16'h00A5});
        chk(r, {1'b1, OFF_PORT_CONFIG, 16'h8052, crc(24'h828052)});
        bus(HOFF_STATUS, 32'h0, 1'b0);
        chk({31'h0, r[1]}, 32'h1);
        xfer({1'b1, OFF_EVENT_MASK, 16'h0});
        chk(r, {1'b0, OFF_TALK_LIMIT, 16'h00A5, crc(24'h2700A5)});
        $display("test crc done");
        tally_and_finish();
    end
endmodule // modem_spi_host_port_tb_top
`default_nettype wire
